// ===== hw/mhd_pkg.sv
package mhd_pkg;

  localparam logic [5:0] OP_SPECIAL   = 6'h00;
  localparam logic [5:0] OP_EXT_GROUP = 6'h1c;
  localparam logic [5:0] OP_ORI       = 6'h0d;
  localparam logic [5:0] OP_BYTE_ST   = 6'h28;
  localparam logic [3:0] OP_COP_HI    = 4'h4;
  localparam logic [4:0] SUB_MOVE_TO  = 5'h04;
  localparam logic [1:0] COP_RESERVED = 2'h3;

  localparam logic [5:0] FN_MFU       = 6'h10;
  localparam logic [5:0] FN_MTU       = 6'h11;
  localparam logic [5:0] FN_MFB       = 6'h12;
  localparam logic [5:0] FN_MTB       = 6'h13;
  localparam logic [5:0] FN_SWIDE     = 6'h18;
  localparam logic [5:0] FN_UWIDE     = 6'h19;
  localparam logic [5:0] FN_OR        = 6'h25;
  localparam logic [5:0] FN_NOR       = 6'h27;
  localparam logic [5:0] FN_MUL3      = 6'h02;

  // multiplier timing for 16-bit operands, in ns and in cycles at 125 MHz
  localparam int CLK_NS         = 8;
  localparam int MUL_LAT_NS     = 24;
  localparam int MUL_REPEAT_NS  = 16;
  localparam int MUL_LAT_CYC    = MUL_LAT_NS / CLK_NS;
  localparam int MUL_REPEAT_CYC = MUL_REPEAT_NS / CLK_NS;
  localparam int MUL_FREE_CYC   = 2;
  localparam int MUL_WIDE_EXTRA = 2;
  localparam logic [2:0] MUL_CNT_ZERO = 3'h0;

  localparam logic [63:0] PROD_RESET  = 64'h0;
  localparam logic [63:0] UNDEF_VALUE = 64'hdead_beef_dead_beef;

  typedef enum logic [2:0] {
    MHD_IDLE = 3'b001,
    MHD_BUSY = 3'b010,
    MHD_DONE = 3'b100
  } mhd_mstate_t;

  typedef enum logic [1:0] {
    MHD_KIND_LOW  = 2'h0,
    MHD_KIND_SIGN = 2'h1,
    MHD_KIND_UNS  = 2'h2
  } mhd_kind_t;

endpackage

// ===== hw/mhd_mul_if.sv
`timescale 1ns/1ns
`default_nettype none
interface mhd_mul_if;
  logic                 start;
  mhd_pkg::mhd_kind_t   kind;
  logic [31:0]          op_a;
  logic [31:0]          op_b;
  logic                 busy;
  logic                 done;
  logic [63:0]          product;
  mhd_pkg::mhd_kind_t   done_kind;

  modport core (output start, kind, op_a, op_b, input busy, done, product, done_kind);
  modport unit (input start, kind, op_a, op_b, output busy, done, product, done_kind);
endinterface
`default_nettype wire

// ===== hw/mhd_mul_unit.sv
`timescale 1ns/1ns
`default_nettype none
module mhd_mul_unit
(
  // clock and reset
  input  wire logic   i_clock,
  input  wire logic   i_rst,
  // request and result
  mhd_mul_if.unit     mul
);

  typedef struct packed {
    mhd_pkg::mhd_mstate_t st;
    logic [2:0]           cnt;
    mhd_pkg::mhd_kind_t   kind;
    logic [63:0]          prod;
  } mhd_mu_state_t;

  mhd_mu_state_t s_reg;
  mhd_mu_state_t s_next;

  always_comb
  begin
    s_next = s_reg;
    case (s_reg.st)
      mhd_pkg::MHD_IDLE:
      begin
        if (mul.start)
        begin
          s_next.st   = mhd_pkg::MHD_BUSY;
          s_next.kind = mul.kind;
          // wide multiplies need more stages than the 3-cycle low product
          s_next.cnt  = (mul.kind == mhd_pkg::MHD_KIND_LOW) ? 3'(mhd_pkg::MUL_LAT_CYC - 1)
                                                             : 3'(mhd_pkg::MUL_LAT_CYC - 1 + mhd_pkg::MUL_WIDE_EXTRA);
          if (mul.kind == mhd_pkg::MHD_KIND_UNS)
            s_next.prod = {32'h0, mul.op_a} * {32'h0, mul.op_b};
          else
            s_next.prod = 64'($signed(mul.op_a) * $signed(mul.op_b));
        end
      end
      mhd_pkg::MHD_BUSY:
      begin
        s_next.cnt = s_reg.cnt - 3'h1;
        if (s_reg.cnt == 3'h1)
          s_next.st = mhd_pkg::MHD_DONE;
      end
      mhd_pkg::MHD_DONE:
        s_next.st = mhd_pkg::MHD_IDLE;
      default:
        s_next.st = mhd_pkg::MHD_IDLE;
    endcase
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      s_reg <= '{st: mhd_pkg::MHD_IDLE, cnt: mhd_pkg::MUL_CNT_ZERO, kind: mhd_pkg::MHD_KIND_LOW,
                 prod: mhd_pkg::PROD_RESET};
    else
      s_reg <= s_next;
  end

  assign mul.busy      = (s_reg.st != mhd_pkg::MHD_IDLE);
  assign mul.done      = (s_reg.st == mhd_pkg::MHD_DONE);
  assign mul.product   = s_reg.prod;
  assign mul.done_kind = s_reg.kind;

  // a low product started from idle reports done exactly 3 cycles later
  mul_latency_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (mul.start && !mul.busy && mul.kind == mhd_pkg::MHD_KIND_LOW) |-> ##3 mul.done)
    else $error("low product latency not 3 cycles");

endmodule
`default_nettype wire

// ===== hw/mhd_datapath.sv
`timescale 1ns/1ns
`default_nettype none
module mhd_datapath
(
  // clock and reset
  input  wire logic         i_clock,
  input  wire logic         i_rst,
  // issued instruction and operand values read from the register file
  input  wire logic         i_valid,
  input  wire logic [31:0]  i_instr,
  input  wire logic [63:0]  i_src_a,
  input  wire logic [63:0]  i_src_b,
  // endianness of the core
  input  wire logic         i_cpu_big_endian_flag,
  // result write to the register file
  output logic              o_wr_en,
  output logic [4:0]        o_wr_index,
  output logic [63:0]       o_wr_data,
  // coprocessor register write
  output logic              o_cop_wr_en,
  output logic [1:0]        o_cop_num,
  output logic [4:0]        o_cop_index,
  output logic [63:0]       o_cop_data,
  // exceptions
  output logic              o_exc_reserved,
  output logic              o_exc_cop_unusable,
  // byte store request
  output logic              o_mem_wr_en,
  output logic [63:0]       o_mem_addr,
  output logic [63:0]       o_mem_data,
  output logic [7:0]        o_mem_byte_en,
  // pipeline stall; a new instruction is refused while one is held, but taken in the low-product stall cycle
  output logic              o_stall
);

  typedef struct packed {
    logic        wr_en;
    logic [4:0]  wr_index;
    logic [63:0] wr_data;
    logic        cop_wr_en;
    logic [1:0]  cop_num;
    logic [4:0]  cop_index;
    logic [63:0] cop_data;
    logic        exc_res;
    logic        exc_cu;
    logic        mem_wr_en;
    logic [63:0] mem_addr;
    logic [63:0] mem_data;
    logic [7:0]  mem_be;
    logic        stall;
    logic [63:0] upper;
    logic [63:0] bottom;
    logic        mul_pend;
    logic [4:0]  mul_dest;
    logic        after_mul;
    logic        held;
    logic [31:0] held_instr;
    logic [63:0] held_a;
    logic [63:0] held_b;
  } mhd_dp_state_t;

  mhd_dp_state_t s_reg;
  mhd_dp_state_t s_next;

  mhd_mul_if mul ();

  mhd_mul_unit u_mul
  (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .mul     (mul.unit)
  );

  // an instruction refused by the interlock is held here and retried
  logic [31:0] ins;
  logic [63:0] va;
  logic [63:0] vb;
  logic        iv;
  logic [5:0]  opc;
  logic [5:0]  fn;
  logic [4:0]  ra;
  logic [4:0]  rb;
  logic [4:0]  rd;
  logic [63:0] eaddr;
  logic [2:0]  lane;
  logic        is_mul3;
  logic        is_wide;
  logic        is_prod_rd;

  always_comb
  begin
    iv         = s_reg.held | i_valid;
    ins        = s_reg.held ? s_reg.held_instr : i_instr;
    va         = s_reg.held ? s_reg.held_a : i_src_a;
    vb         = s_reg.held ? s_reg.held_b : i_src_b;
    opc        = ins[31:26];
    fn         = ins[5:0];
    ra         = ins[25:21];
    rb         = ins[20:16];
    rd         = ins[15:11];
    eaddr      = {{48{ins[15]}}, ins[15:0]} + va;
    lane       = eaddr[2:0] ^ {3{i_cpu_big_endian_flag}};
    is_mul3    = iv && opc == mhd_pkg::OP_EXT_GROUP && fn == mhd_pkg::FN_MUL3;
    is_wide    = iv && opc == mhd_pkg::OP_SPECIAL
                 && (fn == mhd_pkg::FN_SWIDE || fn == mhd_pkg::FN_UWIDE);
    is_prod_rd = iv && opc == mhd_pkg::OP_SPECIAL && (fn == mhd_pkg::FN_MFU || fn == mhd_pkg::FN_MFB);
  end

  logic blocked;

  always_comb
  begin
    // any multiply start waits for the unit; a product read waits for the result
    // a finishing multiply owns the write port and the product registers for that one cycle
    blocked     = ((is_mul3 || is_wide) && mul.busy) || (is_prod_rd && s_reg.mul_pend)
                  || mul.done;
    mul.start   = (is_mul3 || is_wide) && !mul.busy;
    mul.kind    = is_mul3 ? mhd_pkg::MHD_KIND_LOW
                : (fn == mhd_pkg::FN_UWIDE) ? mhd_pkg::MHD_KIND_UNS : mhd_pkg::MHD_KIND_SIGN;
    // only the low 32 bits feed the multiplier; wider bits are the stream's concern
    mul.op_a    = va[31:0];
    mul.op_b    = vb[31:0];

    s_next           = s_reg;
    s_next.wr_en     = 1'b0;
    s_next.cop_wr_en = 1'b0;
    s_next.exc_res   = 1'b0;
    s_next.exc_cu    = 1'b0;
    s_next.mem_wr_en = 1'b0;
    s_next.held       = iv && blocked;
    s_next.held_instr = ins;
    s_next.held_a     = va;
    s_next.held_b     = vb;

    if (iv && !blocked)
    begin
      if (opc[5:2] == mhd_pkg::OP_COP_HI && ra == mhd_pkg::SUB_MOVE_TO)
      begin
        if (opc[1:0] == mhd_pkg::COP_RESERVED)
          s_next.exc_res = 1'b1;
        else
        begin
          s_next.cop_wr_en = 1'b1;
          s_next.cop_num   = opc[1:0];
          s_next.cop_index = rd;
          s_next.cop_data  = vb;
        end
      end
      else if (opc == mhd_pkg::OP_ORI)
      begin
        s_next.wr_en    = 1'b1;
        s_next.wr_index = rb;
        s_next.wr_data  = {va[63:16], va[15:0] | ins[15:0]};
      end
      else if (opc == mhd_pkg::OP_BYTE_ST)
      begin
        s_next.mem_wr_en = 1'b1;
        s_next.mem_addr  = eaddr;
        s_next.mem_data  = {56'h0, vb[7:0]} << {lane, 3'h0};
        s_next.mem_be    = 8'h01 << lane;
      end
      else if (is_mul3)
      begin
        s_next.mul_pend = 1'b1;
        s_next.mul_dest = rd;
        s_next.upper    = mhd_pkg::UNDEF_VALUE;
        s_next.bottom   = mhd_pkg::UNDEF_VALUE;
      end
      else if (is_wide)
        s_next.mul_pend = 1'b1;
      else if (opc == mhd_pkg::OP_SPECIAL)
      begin
        case (fn)
          mhd_pkg::FN_NOR:
          begin
            s_next.wr_en    = 1'b1;
            s_next.wr_index = rd;
            s_next.wr_data  = ~(va | vb);
          end
          mhd_pkg::FN_OR:
          begin
            s_next.wr_en    = 1'b1;
            s_next.wr_index = rd;
            s_next.wr_data  = va | vb;
          end
          mhd_pkg::FN_MTU:
          begin
            s_next.upper     = va;
            s_next.bottom    = s_reg.after_mul ? mhd_pkg::UNDEF_VALUE : s_reg.bottom;
            s_next.after_mul = 1'b0;
          end
          mhd_pkg::FN_MTB:
          begin
            s_next.bottom    = va;
            s_next.upper     = s_reg.after_mul ? mhd_pkg::UNDEF_VALUE : s_reg.upper;
            s_next.after_mul = 1'b0;
          end
          mhd_pkg::FN_MFU:
          begin
            s_next.wr_en     = 1'b1;
            s_next.wr_index  = rd;
            s_next.wr_data   = s_reg.upper;
            s_next.after_mul = 1'b0;
          end
          mhd_pkg::FN_MFB:
          begin
            s_next.wr_en     = 1'b1;
            s_next.wr_index  = rd;
            s_next.wr_data   = s_reg.bottom;
            s_next.after_mul = 1'b0;
          end
          default:
          begin
            s_next.wr_en = 1'b0;
          end
        endcase
      end
    end

    // completion; the product path has no conflict with the issue path above
    if (mul.done)
    begin
      s_next.mul_pend = 1'b0;
      if (mul.done_kind == mhd_pkg::MHD_KIND_LOW)
      begin
        s_next.wr_en    = 1'b1;
        s_next.wr_index = s_reg.mul_dest;
        s_next.wr_data  = {{32{mul.product[31]}}, mul.product[31:0]};
      end
      else
      begin
        s_next.bottom    = {{32{mul.product[31]}}, mul.product[31:0]};
        s_next.upper     = {{32{mul.product[63]}}, mul.product[63:32]};
        s_next.after_mul = 1'b1;
      end
    end

    // the low product holds the pipe for all but its last 2 cycles, one cycle at 3-cycle latency
    s_next.stall = s_next.held || (mul.start && mul.kind == mhd_pkg::MHD_KIND_LOW);
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign o_wr_en            = s_reg.wr_en;
  assign o_wr_index         = s_reg.wr_index;
  assign o_wr_data          = s_reg.wr_data;
  assign o_cop_wr_en        = s_reg.cop_wr_en;
  assign o_cop_num          = s_reg.cop_num;
  assign o_cop_index        = s_reg.cop_index;
  assign o_cop_data         = s_reg.cop_data;
  assign o_exc_reserved     = s_reg.exc_res;
  assign o_exc_cop_unusable = s_reg.exc_cu;
  assign o_mem_wr_en        = s_reg.mem_wr_en;
  assign o_mem_addr         = s_reg.mem_addr;
  assign o_mem_data         = s_reg.mem_data;
  assign o_mem_byte_en      = s_reg.mem_be;
  assign o_stall            = s_reg.stall;

  cop3_reserved_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (iv && !blocked && ins[31:28] == mhd_pkg::OP_COP_HI && ins[27:26] == mhd_pkg::COP_RESERVED
     && ra == mhd_pkg::SUB_MOVE_TO) |=> (o_exc_reserved && !o_cop_wr_en))
    else $error("coprocessor 3 write did not raise reserved");

  cop_write_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (iv && !blocked && ins[31:28] == mhd_pkg::OP_COP_HI && ins[27:26] != mhd_pkg::COP_RESERVED
     && ra == mhd_pkg::SUB_MOVE_TO) |=> (o_cop_wr_en && o_cop_data == $past(vb) && o_cop_index == $past(rd)))
    else $error("coprocessor write wrong");

  nor_result_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (iv && !blocked && !mul.done && opc == mhd_pkg::OP_SPECIAL && fn == mhd_pkg::FN_NOR)
    |=> (o_wr_en && o_wr_data == ~($past(va) | $past(vb))))
    else $error("nor result wrong");

  ori_result_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (iv && !blocked && !mul.done && opc == mhd_pkg::OP_ORI)
    |=> (o_wr_index == $past(rb) && o_wr_data[63:16] == $past(va[63:16])))
    else $error("immediate or changed upper bits");

  byte_lane_a: assert property (@(posedge i_clock) disable iff (i_rst)
    o_mem_wr_en |-> (o_mem_byte_en == (8'h01 << (o_mem_addr[2:0] ^ {3{$past(i_cpu_big_endian_flag)}}))))
    else $error("byte lane wrong");

  mul3_stall_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (mul.start && mul.kind == mhd_pkg::MHD_KIND_LOW && !s_reg.held) |=> o_stall ##1 !o_stall)
    else $error("low product stall length wrong");

  mul3_write_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (mul.start && mul.kind == mhd_pkg::MHD_KIND_LOW) |-> ##4 (o_wr_en && o_wr_index == $past(rd, 4)))
    else $error("low product not written to destination");

  wide_hilo_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (mul.done && mul.done_kind != mhd_pkg::MHD_KIND_LOW)
    |=> (s_reg.bottom[63:32] == {32{s_reg.bottom[31]}} && s_reg.upper[31:0] == $past(mul.product[63:32])))
    else $error("wide product split wrong");

  read_wait_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (is_prod_rd && s_reg.mul_pend) |=> !o_wr_en || s_reg.held || $past(mul.done))
    else $error("product read not held");

  or_result_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (iv && !blocked && opc == mhd_pkg::OP_SPECIAL && fn == mhd_pkg::FN_OR)
    |=> (o_wr_en && o_wr_index == $past(rd) && o_wr_data == ($past(va) | $past(vb))))
    else $error("or result wrong");

  store_addr_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (iv && !blocked && opc == mhd_pkg::OP_BYTE_ST)
    |=> (o_mem_wr_en && $onehot(o_mem_byte_en)
         && o_mem_addr == $past(va) + {{48{$past(ins[15])}}, $past(ins[15:0])}))
    else $error("byte store address wrong");

  upper_load_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (iv && !blocked && opc == mhd_pkg::OP_SPECIAL && fn == mhd_pkg::FN_MTU) |=> (s_reg.upper == $past(va)))
    else $error("upper product register not loaded");

  bottom_load_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (iv && !blocked && opc == mhd_pkg::OP_SPECIAL && fn == mhd_pkg::FN_MTB) |=> (s_reg.bottom == $past(va)))
    else $error("bottom product register not loaded");

  mul3_undef_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (iv && !blocked && is_mul3)
    |=> (s_reg.upper == mhd_pkg::UNDEF_VALUE && s_reg.bottom == mhd_pkg::UNDEF_VALUE))
    else $error("product registers kept after low product");

  wide_low_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (mul.done && mul.done_kind != mhd_pkg::MHD_KIND_LOW)
    |=> (s_reg.bottom[31:0] == $past(mul.product[31:0]) && s_reg.upper[63:32] == {32{s_reg.upper[31]}}))
    else $error("wide product low word or upper sign wrong");

endmodule
`default_nettype wire

// ===== sim/mhd_datapath_tb.sv
`timescale 1ns/1ns
`default_nettype none
module mhd_datapath_tb;
  logic        i_clock;
  logic        i_rst;
  logic        i_valid;
  logic [31:0] i_instr;
  logic [63:0] i_src_a;
  logic [63:0] i_src_b;
  logic        i_cpu_big_endian_flag;
  logic        o_wr_en;
  logic [4:0]  o_wr_index;
  logic [63:0] o_wr_data;
  logic        o_cop_wr_en;
  logic [1:0]  o_cop_num;
  logic [4:0]  o_cop_index;
  logic [63:0] o_cop_data;
  logic        o_exc_reserved;
  logic        o_exc_cop_unusable;
  logic        o_mem_wr_en;
  logic [63:0] o_mem_addr;
  logic [63:0] o_mem_data;
  logic [7:0]  o_mem_byte_en;
  logic        o_stall;
  integer      fails;
  integer      checks;
  integer      seed;
  int          k;
  int          j;
  logic [63:0] a;
  logic [63:0] b;
  logic [63:0] t;
  logic [63:0] ea;
  logic [15:0] off;
  logic [2:0]  lane;

  mhd_datapath dut_u (
    .i_clock              (i_clock),
    .i_rst                (i_rst),
    .i_valid              (i_valid),
    .i_instr              (i_instr),
    .i_src_a              (i_src_a),
    .i_src_b              (i_src_b),
    .i_cpu_big_endian_flag(i_cpu_big_endian_flag),
    .o_wr_en              (o_wr_en),
    .o_wr_index           (o_wr_index),
    .o_wr_data            (o_wr_data),
    .o_cop_wr_en          (o_cop_wr_en),
    .o_cop_num            (o_cop_num),
    .o_cop_index          (o_cop_index),
    .o_cop_data           (o_cop_data),
    .o_exc_reserved       (o_exc_reserved),
    .o_exc_cop_unusable   (o_exc_cop_unusable),
    .o_mem_wr_en          (o_mem_wr_en),
    .o_mem_addr           (o_mem_addr),
    .o_mem_data           (o_mem_data),
    .o_mem_byte_en        (o_mem_byte_en),
    .o_stall              (o_stall)
  );

  initial i_clock = 1'b0;
  always #4 i_clock = ~i_clock;

  function automatic logic [63:0] rnd();
    return {$random(seed), $random(seed)};
  endfunction

  function automatic logic [63:0] sx(input logic [31:0] v);
    return {{32{v[31]}}, v};
  endfunction

  // register-type word; source fields are fixed since operand values come on i_src_a/b
  function automatic logic [31:0] enc(input logic [5:0] op, input logic [4:0] rd, input logic [5:0] fn);
    return {op, 5'h01, 5'h02, rd, 5'h00, fn};
  endfunction

  task automatic chk(input logic [79:0] got, input logic [79:0] exp, input string what);
    checks = checks + 1;
    if (got !== exp)
    begin
      fails = fails + 1;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // holds off while the core stalls, presents the word for one edge only;
  // an idle edge first, so valid never falls and rises again in one time step
  task automatic issue(input logic [31:0] ins, input logic [63:0] sa, input logic [63:0] sb);
    int n;
    n = 0;
    @(negedge i_clock);
    while (o_stall !== 1'b0 && n < 20)
    begin
      @(negedge i_clock);
      n++;
    end
    i_valid = 1'b1;
    i_instr = ins;
    i_src_a = sa;
    i_src_b = sb;
    @(negedge i_clock);
    i_valid = 1'b0;
  endtask

  // a product read may be held back by the interlock, so the write is awaited
  task automatic wait_wr(input logic [4:0] idx, input logic [63:0] d);
    int n;
    n = 0;
    while (o_wr_en !== 1'b1 && n < 20)
    begin
      @(negedge i_clock);
      n++;
    end
    chk({o_wr_en, o_wr_index, o_wr_data}, {1'b1, idx, d}, "register write");
  endtask

  task automatic finish_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    #400000;
    fails = fails + 1;
    $display("mismatch at %0t: run did not complete", $time);
    finish_test();
  end

  initial
  begin
    fails = 0;
    checks = 0;
    seed = 32'h8ade82e2;
    i_rst = 1'b1;
    i_valid = 1'b0;
    i_instr = 32'h0;
    i_src_a = 64'h0;
    i_src_b = 64'h0;
    i_cpu_big_endian_flag = 1'b0;
    repeat (20) @(negedge i_clock);
    i_rst = 1'b0;
    // every byte lane under both endian settings, offset sign corners first
    for (k = 0; k < 16; k++)
    begin
      a = rnd();
      b = rnd();
      off = (k == 0) ? 16'h8000 : (k == 1) ? 16'h7ff8 : 16'($random(seed)) & 16'hfff8;
      a[2:0] = k[2:0];
      i_cpu_big_endian_flag = k[3];
      ea = a + {{48{off[15]}}, off};
      lane = ea[2:0] ^ {3{k[3]}};
      issue({mhd_pkg::OP_BYTE_ST, 5'h03, 5'h04, off}, a, b);
      chk({o_mem_wr_en, o_mem_addr, o_mem_byte_en}, {1'b1, ea, 8'h01 << lane}, "store address");
      chk(o_mem_data[8*lane +: 8], b[7:0], "store data");
    end
    for (k = 0; k < 4; k++)
    begin
      b = rnd();
      issue({mhd_pkg::OP_COP_HI, k[1:0], mhd_pkg::SUB_MOVE_TO, 5'h02, 5'h09, 11'h000}, a, b);
      if (k == 3)
        chk({o_exc_reserved, o_exc_cop_unusable, o_cop_wr_en}, 3'b100, "reserved coprocessor");
      else
        chk({o_cop_wr_en, o_cop_num, o_cop_index, o_cop_data, o_exc_reserved}, {1'b1, k[1:0], 5'h09, b, 1'b0},
            "coprocessor write");
    end
    // logic ops double as the two spacers the stream owes before each wide multiply
    for (k = 0; k < 12; k++)
    begin
      a = rnd();
      b = rnd();
      issue(enc(mhd_pkg::OP_SPECIAL, 5'h05, mhd_pkg::FN_NOR), a, b);
      chk({o_wr_en, o_wr_index, o_wr_data}, {1'b1, 5'h05, ~(a | b)}, "nor");
      issue(enc(mhd_pkg::OP_SPECIAL, 5'h06, mhd_pkg::FN_OR), a, b);
      chk({o_wr_en, o_wr_index, o_wr_data}, {1'b1, 5'h06, a | b}, "or");
      issue({mhd_pkg::OP_ORI, 5'h01, 5'h0e, b[15:0]}, a, b);
      chk({o_wr_en, o_wr_index, o_wr_data}, {1'b1, 5'h0e, a[63:16], a[15:0] | b[15:0]}, "or immediate");
      a = (k < 2) ? sx(32'h80000000 | {31'h0, k[0]}) : sx($random(seed));
      b = (k < 2) ? sx(32'hffffffff) : sx($random(seed));
      if (k[0])
        t = {32'h0, a[31:0]} * {32'h0, b[31:0]};
      else
        t = $signed(a[31:0]) * $signed(b[31:0]);
      issue(enc(mhd_pkg::OP_SPECIAL, 5'h00, k[0] ? mhd_pkg::FN_UWIDE : mhd_pkg::FN_SWIDE), a, b);
      issue(enc(mhd_pkg::OP_SPECIAL, 5'h07, mhd_pkg::FN_MFB), a, b);
      wait_wr(5'h07, sx(t[31:0]));
      issue(enc(mhd_pkg::OP_SPECIAL, 5'h08, mhd_pkg::FN_MFU), a, b);
      wait_wr(5'h08, sx(t[63:32]));
    end
    for (j = 0; j < 2; j++)
    begin
      a = sx($random(seed));
      issue(enc(mhd_pkg::OP_SPECIAL, 5'h05, mhd_pkg::FN_NOR), a, b);
      issue(enc(mhd_pkg::OP_SPECIAL, 5'h05, mhd_pkg::FN_NOR), a, b);
      issue(enc(mhd_pkg::OP_SPECIAL, 5'h00, mhd_pkg::FN_SWIDE), a, a);
      repeat (10) @(negedge i_clock);
      issue(enc(mhd_pkg::OP_SPECIAL, 5'h00, j ? mhd_pkg::FN_MTB : mhd_pkg::FN_MTU), a, b);
      issue(enc(mhd_pkg::OP_SPECIAL, 5'h0a, j ? mhd_pkg::FN_MFB : mhd_pkg::FN_MFU), a, b);
      wait_wr(5'h0a, a);
      issue(enc(mhd_pkg::OP_SPECIAL, 5'h0b, j ? mhd_pkg::FN_MFU : mhd_pkg::FN_MFB), a, b);
      wait_wr(5'h0b, mhd_pkg::UNDEF_VALUE);
    end
    // 16-bit operands give the short fixed timing
    for (k = 0; k < 4; k++)
    begin
      a = (k == 0) ? 64'hffff : {48'h0, 16'($random(seed))};
      b = (k == 0) ? 64'hffff : {48'h0, 16'($random(seed))};
      t = a[31:0] * b[31:0];
      issue(enc(mhd_pkg::OP_EXT_GROUP, 5'h0c, mhd_pkg::FN_MUL3), a, b);
      chk({o_stall, o_wr_en}, 2'b10, "multiply stall");
      @(negedge i_clock);
      chk({o_stall, o_wr_en}, 2'b00, "multiply stall release");
      repeat (2) @(negedge i_clock);
      chk({o_wr_en, o_wr_index, o_wr_data[31:0]}, {1'b1, 5'h0c, t[31:0]}, "product");
    end
    issue(enc(mhd_pkg::OP_SPECIAL, 5'h0d, mhd_pkg::FN_MFU), a, b);
    wait_wr(5'h0d, mhd_pkg::UNDEF_VALUE);
    issue(enc(mhd_pkg::OP_SPECIAL, 5'h0f, mhd_pkg::FN_MFB), a, b);
    wait_wr(5'h0f, mhd_pkg::UNDEF_VALUE);
    finish_test();
  end
endmodule
`default_nettype wire
